// File: tcf_pkg.sv
// Constants for the turns-count fault flag block.
// Assumes a 16-bit serial register interface outside that decodes addresses.
//
// Overview of operation
// RQ1 - Diagnostics keep running in normal operation and in low power state.
// RQ2 - Flags are readable only through the serial register port, no other output.
// RQ3 - Warning and overflow flags sit in the registers holding the turns count.
// RQ4 - Flags raised in normal operation stay latched through low power state.
// RQ5 - Flags raised in low power state stay set after returning to normal.
// RQ6 - Only a turns count reset clears flags; reads and mode changes do not.
// RQ7 - Controller writes control register 0x0D to reset count and clear flags.
// RQ8 - Warning at bit 13, overflow at bit 12 in 0x13, 0x1A, 0x19, 0x1B.
// RQ9 - Bit 15 carries the OR of warning and overflow, live and latched.
// RQ10 - One reset command clears live and latched flags of both channels.
package tcf_pkg;
  localparam logic [7:0]  ADDR_TURNS_CONTROL     = 8'h0D;
  localparam logic [7:0]  ADDR_PRIMARY_LIVE      = 8'h13;
  localparam logic [7:0]  ADDR_PRIMARY_HELD      = 8'h19;
  localparam logic [7:0]  ADDR_SECONDARY_LIVE    = 8'h1A;
  localparam logic [7:0]  ADDR_SECONDARY_HELD    = 8'h1B;
  localparam int          BIT_ANY_FAULT          = 15;
  localparam int          BIT_WARNING            = 13;
  localparam int          BIT_OVERFLOW           = 12;
  localparam int          BIT_TURNS_RESET        = 0;
  localparam int          COUNT_W                = 12;
  localparam logic [15:0] RESET_VALUE            = 16'h0000;
endpackage

// File: tcf_flags.sv
// Turns-count fault flags, live and latched, for both channels.
// Assumes fault events and counts come from same-clock counting logic.
`timescale 1ns/1ps
module tcf_flags
  import tcf_pkg::*;
(
  input  wire logic                     mclk,
  input  wire logic                     rst_b,
  input  wire logic                     low_power_state,
  input  wire logic [1:0]               warn_event,
  input  wire logic [1:0]               ovf_event,
  input  wire logic [tcf_pkg::COUNT_W-1:0] count_primary,
  input  wire logic [tcf_pkg::COUNT_W-1:0] count_secondary,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [15:0]              reg_wdata,
  output logic      [15:0]              reg_rdata,
  output logic                          turns_reset_pulse
);
  import tcf_pkg::*;

  // Channel 0 is primary and channel 1 secondary in every vector below
  localparam int NUM_CHAN = 2;

  // Flag vectors gathered from the channel slices
  logic [NUM_CHAN-1:0]              warn_live;
  logic [NUM_CHAN-1:0]              ovf_live;
  logic [NUM_CHAN-1:0]              warn_held;
  logic [NUM_CHAN-1:0]              ovf_held;

  // Read path
  logic [NUM_CHAN-1:0][COUNT_W-1:0] chan_count;
  logic [NUM_CHAN-1:0][15:0]        live_word;
  logic [NUM_CHAN-1:0][15:0]        held_word;
  logic                             sel_flag;
  logic                             sel_held;
  logic                             sel_chan;
  logic [15:0]                      nxt_rdata;
  logic [15:0]                      rdata_ff;

  // Command path
  logic                             nxt_clear;
  logic                             nxt_pulse;
  logic                             pulse_ff;

  // Reset command is a self-clearing bit; nothing of it is stored
  function automatic logic is_reset_cmd(input logic        wr,
                                        input logic [7:0]  addr,
                                        input logic [15:0] wdata);
    logic hit;
    hit = wr && (addr == ADDR_TURNS_CONTROL);
    return hit && wdata[BIT_TURNS_RESET];
  endfunction

  // True for the four count registers that carry fault flags
  function automatic logic is_flag_reg(input logic [7:0] addr);
    logic hit;
    case (addr)
      ADDR_PRIMARY_LIVE,
      ADDR_PRIMARY_HELD,
      ADDR_SECONDARY_LIVE,
      ADDR_SECONDARY_HELD: hit = 1'b1;
      default:             hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Channel owning a count register: 0 primary, 1 secondary
  function automatic logic reg_channel(input logic [7:0] addr);
    logic ch;
    case (addr)
      ADDR_SECONDARY_LIVE,
      ADDR_SECONDARY_HELD: ch = 1'b1;
      default:             ch = 1'b0;
    endcase
    return ch;
  endfunction

  // Held registers show the latched copy, the others the live one
  function automatic logic reg_is_held(input logic [7:0] addr);
    logic held;
    case (addr)
      ADDR_PRIMARY_HELD,
      ADDR_SECONDARY_HELD: held = 1'b1;
      default:             held = 1'b0;
    endcase
    return held;
  endfunction

  // Set wins over a clear in the same cycle, so no fault is lost
  function automatic logic flag_next(input logic cur,
                                     input logic clr,
                                     input logic evt);
    return (clr ? 1'b0 : cur) | evt;
  endfunction

  // Count in the low bits; bit 14 is not used here and reads 0
  function automatic logic [15:0] pack_reg(input logic [COUNT_W-1:0] cnt,
                                           input logic               w,
                                           input logic               o);
    logic [15:0] r;
    r = RESET_VALUE;
    r[COUNT_W-1:0]   = cnt;          // see RQ3
    r[BIT_WARNING]   = w;            // see RQ8
    r[BIT_OVERFLOW]  = o;            // see RQ8
    r[BIT_ANY_FAULT] = w | o;        // see RQ9
    return r;
  endfunction

  // Counts are indexed like the flag vectors
  assign chan_count[0] = count_primary;
  assign chan_count[1] = count_secondary;

  assign nxt_clear = is_reset_cmd(reg_wr, reg_addr, reg_wdata);      // see RQ7
  assign nxt_pulse = nxt_clear;

  // Counting logic sees the command one cycle later, with the flags
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_ff <= 1'b0;
    end else begin
      pulse_ff <= nxt_pulse;                                         // see RQ7
    end
  end

  assign turns_reset_pulse = pulse_ff;

  // One slice per channel; both slices share the single reset command
  generate
    for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      logic warn_live_ff;
      logic ovf_live_ff;
      logic warn_held_ff;
      logic ovf_held_ff;
      logic nxt_warn_live;
      logic nxt_ovf_live;
      logic nxt_warn_held;
      logic nxt_ovf_held;

      // Mode is not looked at, so faults land in either power state
      assign nxt_warn_live = flag_next(warn_live_ff, nxt_clear, warn_event[ch]); // see RQ1
      assign nxt_ovf_live  = flag_next(ovf_live_ff, nxt_clear, ovf_event[ch]);   // see RQ1
      // Latched copies ride through mode changes both ways
      assign nxt_warn_held = flag_next(warn_held_ff, nxt_clear, warn_event[ch]); // see RQ4 RQ5
      assign nxt_ovf_held  = flag_next(ovf_held_ff, nxt_clear, ovf_event[ch]);   // see RQ4 RQ5

      // One register per flag, cleared by reset
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          warn_live_ff <= 1'b0;
        end else begin
          warn_live_ff <= nxt_warn_live;                             // see RQ6 RQ10
        end
      end

      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          ovf_live_ff <= 1'b0;
        end else begin
          ovf_live_ff <= nxt_ovf_live;                               // see RQ6 RQ10
        end
      end

      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          warn_held_ff <= 1'b0;
        end else begin
          warn_held_ff <= nxt_warn_held;                             // see RQ6 RQ10
        end
      end

      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          ovf_held_ff <= 1'b0;
        end else begin
          ovf_held_ff <= nxt_ovf_held;                               // see RQ6 RQ10
        end
      end

      assign warn_live[ch] = warn_live_ff;
      assign ovf_live[ch]  = ovf_live_ff;
      assign warn_held[ch] = warn_held_ff;
      assign ovf_held[ch]  = ovf_held_ff;

      assign live_word[ch] = pack_reg(chan_count[ch], warn_live_ff, ovf_live_ff);
      assign held_word[ch] = pack_reg(chan_count[ch], warn_held_ff, ovf_held_ff);
    end
  endgenerate

  // Decode shared by the read mux
  always_comb begin
    sel_flag = is_flag_reg(reg_addr);
    sel_held = reg_is_held(reg_addr);
    sel_chan = reg_channel(reg_addr);
  end

  // Unmapped and control addresses read as zero
  always_comb begin
    nxt_rdata = RESET_VALUE;
    if (sel_flag) begin
      if (sel_held) begin
        nxt_rdata = held_word[sel_chan];
      end else begin
        nxt_rdata = live_word[sel_chan];
      end
    end
  end

  // Captured only on a read strobe; reads never touch the flags
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= RESET_VALUE;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;                                         // see RQ2 RQ6
    end
  end

  assign reg_rdata = rdata_ff;
endmodule

// File: tcf_flags_properties.sv
// Port checks of the turns fault flags; bound to tcf_flags, sees its ports only.
`timescale 1ns/1ps
module tcf_flags_properties (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic        turns_reset_pulse,
  input wire logic [1:0]  warn_event,
  input wire logic [1:0]  ovf_event,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire cmd = reg_wr && reg_addr == 8'h0D && reg_wdata[0];
  wire ok = !{warn_event, ovf_event};
  wire fr = reg_rd && reg_addr inside {8'h13, 8'h19, 8'h1A, 8'h1B};
  a_pulse_cmd: assert property (cmd |=> turns_reset_pulse) else $error("pulse");
  a_no_stray: assert property (turns_reset_pulse |-> $past(cmd)) else $error("stray");
  a_wr_quiet: assert property (reg_wr && !cmd |=> !turns_reset_pulse) else $error("wr");
  a_rd_hold: assert property (!$past(reg_rd)|->$stable(reg_rdata)) else $error("hold");
  a_unmapped_zero: assert property (reg_rd && !fr && reg_addr != 8'h0D |=> !reg_rdata)
    else $error("unmapped");
  a_any_fault: assert property (fr|=>reg_rdata[15]==|reg_rdata[13:12]) else $error("or");
  a_bit14_zero: assert property (fr |=> !reg_rdata[14]) else $error("bit14");
  a_flags_clear: assert property (cmd && ok ##1 ok ##1 fr && ok
    |=> !reg_rdata[13:12]) else $error("clear");
  a_warn_kept: assert property (warn_event[0] ##1 !cmd ##1 reg_rd && reg_addr == 8'h19
    |=> reg_rdata[13]) else $error("warning not kept");
  a_ovf_kept: assert property (ovf_event[0] ##1 !cmd ##1 reg_rd && reg_addr == 8'h13
    |=> reg_rdata[12]) else $error("overflow not kept");
  a_set_wins: assert property (warn_event[0] && cmd ##1 !cmd ##1 reg_rd
    && reg_addr == 8'h13 |=> reg_rdata[13]) else $error("event lost to clear");
endmodule
bind tcf_flags tcf_flags_properties u_props (.*);

// File: tcf_host.sv
// Controller model: one register request at a time, launched just after mclk rises.
`timescale 1ns/1ps
module tcf_host (input wire logic mclk, output logic reg_wr, reg_rd,
  output logic [7:0] reg_addr, output logic [15:0] reg_wdata);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 26'h0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk) #1 {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    // Released bus shows the inverse so stale values cannot pass
    @(posedge mclk) #1 {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
  endtask
endmodule

// File: tcf_flags_tb.sv
// Bench: flags raised, kept over low power, then cleared; tcf_host drives the registers.
`timescale 1ns/1ps
module tcf_flags_tb;
  logic mclk = 0, rst_b = 0, low_power_state = 0, reg_wr, reg_rd, turns_reset_pulse;
  logic [1:0] warn_event = 0, ovf_event = 0;
  logic [11:0] count_primary = 12'hA5C, count_secondary = 12'h3C1;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  int err_total = 0, n_checks = 0, cyc = 0;
  always #10 mclk = ~mclk;
  always @(posedge mclk) if (++cyc > 400) begin err_total++; stop_test(); end
  tcf_host u_host (
    .mclk      (mclk),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata)
  );
  tcf_flags u_dut (
    .mclk              (mclk),
    .rst_b             (rst_b),
    .low_power_state   (low_power_state),
    .warn_event        (warn_event),
    .ovf_event         (ovf_event),
    .count_primary     (count_primary),
    .count_secondary   (count_secondary),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_rdata         (reg_rdata),
    .turns_reset_pulse (turns_reset_pulse)
  );
  task automatic rdc(input logic [7:0] a, input logic [15:0] e, m = 16'hF000);
    u_host.xfer(1'b0, a, 16'h0000);
    n_checks++;
    if ((reg_rdata & m) !== e) begin
      err_total++;
      $display("ERROR reg %h exp %h got %h", a, e, reg_rdata & m);
    end
  endtask
  task automatic chk_bit(input string name, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s exp %b got %b", name, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk); #1 rst_b = 1;
    // Primary warning and secondary overflow, then into low power
    @(posedge mclk) #1 {warn_event, ovf_event} = 4'b0110;
    @(posedge mclk) #1 {warn_event, ovf_event, low_power_state} = 5'h01;
    rdc(8'h19, 16'hA000);
    // Secondary warning and primary overflow raised while in low power
    @(posedge mclk) #1 {warn_event, ovf_event} = 4'b1001;
    @(posedge mclk) #1 {warn_event, ovf_event, low_power_state} = 5'h00;
    rdc(8'h13, 16'hBA5C, 16'hFFFF);
    repeat (2) rdc(8'h1A, 16'hB3C1, 16'hFFFF);
    rdc(8'h20, 16'h0000, 16'hFFFF);
    u_host.xfer(1'b1, 8'h0D, 16'h0000);
    chk_bit("pulse", 1'b0, turns_reset_pulse);
    rdc(8'h1B, 16'hB000);
    u_host.xfer(1'b1, 8'h0D, 16'h0001);
    chk_bit("pulse", 1'b1, turns_reset_pulse);
    rdc(8'h19, 16'h0000);
    rdc(8'h1A, 16'h0000);
    rdc(8'h13, 16'h0A5C, 16'hFFFF);
    rdc(8'h1B, 16'h0000);
    chk_bit("pulse", 1'b0, turns_reset_pulse);
    // Primary warning in the very cycle of a reset command is kept
    fork
      u_host.xfer(1'b1, 8'h0D, 16'h0001);
      begin
        @(posedge mclk) #1 warn_event = 2'b01;
        @(posedge mclk) #1 warn_event = 2'b00;
      end
    join
    chk_bit("pulse", 1'b1, turns_reset_pulse);
    rdc(8'h13, 16'hAA5C, 16'hFFFF);
    rdc(8'h1A, 16'h0000);
    stop_test();
  end
endmodule
